// ==== design/cycle_timer.sv ====
// Loadable down counter that reports a minimum spacing still running
`timescale 1ns/1ps
module cycle_timer #(
  parameter int WIDTH = 14
) (
  input  wire logic             core_clk,    // Core clock
  input  wire logic             sys_rst,     // Synchronous reset
  input  wire logic             load,        // Start a new wait
  input  wire logic [WIDTH-1:0] load_value,  // Cycles to wait
  output logic                  busy         // Wait still running
);

  logic [WIDTH-1:0] count;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // A new load restarts the wait; otherwise count down to zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (busy) begin
      count <= count - 1'b1;
    end
  end

  assign busy = (count != '0);

endmodule

// ==== design/ddr_command_timing_guard.sv ====
// Controller-side command timing guard for a four-bank DDR SDRAM
//
// Summary of operation
// RULE1: Same-bank ACTIVE to ACTIVE or REFRESH spaced by row cycle time.
// RULE2: After REFRESH, wait refresh cycle time before ACTIVE or REFRESH.
// RULE3: READ or WRITE waits the activate-to-column delay after ACTIVE.
// RULE4: Auto-precharge column command obeys the same activate delay.
// RULE5: ACTIVE commands to different banks spaced by bank-to-bank time.
// RULE6: After auto-precharge write, wait recovery plus precharge to reopen.
// RULE7: READ waits write-to-read turnaround after last write data.
// RULE8: After self-refresh exit, non-read commands wait 75 ns.
// RULE9: After self-refresh exit, READ waits 200 clock cycles.
// RULE10: Average refresh interval 15.6 us, or 3.9 us when hot.
// RULE11: Never more than eight refresh commands owed to the device.
// RULE12: Device refreshes with its own counters; no row address given.
// RULE13: After unstable-clock power-down exit, READ waits 200 cycles.
// RULE14: CAS latency 4 is refused on these two speed grades.
// RULE15: Bank stays open at least 40 ns and at most 70 us; code checks the minimum on PRE only and only flags the maximum.
// RULE16: Nanosecond minimums rounded up to cycles, timed per bank and type.
`timescale 1ns/1ps
module ddr_command_timing_guard #(
  parameter int CW             = 14,                     // Timer width
  parameter int BURST_CYCLES   = 2,                      // Burst length / 2
  parameter int OPEN_MAX_CYC   = ddr_guard_pkg::OPEN_MAX // Bank open limit
) (
  input  wire logic                      core_clk,         // Core clock
  input  wire logic                      sys_rst,          // Sync reset
  input  wire logic                      speed_slow,       // Slower grade
  input  wire logic                      temp_hot,         // Above 85 C
  input  wire ddr_guard_pkg::cas_latency_type cas_latency_setting, // CL
  input  wire logic                      pd_exit_unstable, // Exit pulse
  input  wire logic                      cmd_valid,        // Request
  input  wire ddr_guard_pkg::cmd_type    cmd_code,         // Command
  input  wire logic [1:0]                cmd_bank,         // Bank
  input  wire logic [11:0]               cmd_addr,         // Row/col/mode
  input  wire logic                      cmd_autopre,      // Auto-precharge
  output logic                           cmd_ready,        // May issue
  output logic                           ddr_cke,          // Clock enable
  output logic                           ddr_cs_n,         // Chip select
  output logic                           ddr_ras_n,        // Row strobe
  output logic                           ddr_cas_n,        // Column strobe
  output logic                           ddr_we_n,         // Write enable
  output logic [1:0]                     ddr_ba,           // Bank address
  output logic [11:0]                    ddr_addr,         // Address
  output logic                           refresh_due,      // Refresh owed
  output logic                           refresh_urgent,   // Owed at limit
  output logic [3:0]                     bank_overdue,     // Open too long
  output logic                           cl_refused,       // CL 4 chosen
  output logic                           in_self_refresh   // Self refresh
);

  localparam int NB = ddr_guard_pkg::BANKS;

  // ---------------------------------------------------------------
  // Timing selection
  // ---------------------------------------------------------------
  // Spacing of n cycles means the timer blocks n-1 cycles after accept
  function automatic logic [CW-1:0] spc(input int n);
    return CW'((n < 1) ? 0 : n - 1);
  endfunction

  // Pick the figure for the grade in use
  function automatic int by_grade(input logic slow, input int f,
                                  input int s);
    return slow ? s : f;
  endfunction

  int t_rc, t_rcd, t_rp, t_rrd, t_wr, t_wtr;
  always_comb begin
    t_rc  = by_grade(speed_slow, ddr_guard_pkg::ROW_CYCLE_FAST,
                     ddr_guard_pkg::ROW_CYCLE_SLOW);            // RULE16
    t_rcd = by_grade(speed_slow, ddr_guard_pkg::RCD_FAST,
                     ddr_guard_pkg::RCD_SLOW);
    t_rp  = by_grade(speed_slow, ddr_guard_pkg::PRECHARGE_FAST,
                     ddr_guard_pkg::PRECHARGE_SLOW);
    t_rrd = by_grade(speed_slow, ddr_guard_pkg::RRD_FAST,
                     ddr_guard_pkg::RRD_SLOW);
    t_wr  = by_grade(speed_slow, ddr_guard_pkg::WRITE_REC_FAST,
                     ddr_guard_pkg::WRITE_REC_SLOW);
    t_wtr = by_grade(speed_slow, ddr_guard_pkg::WRITE_TO_READ_FAST_CYC,
                     ddr_guard_pkg::WRITE_TO_READ_SLOW_CYC);
  end

  // ---------------------------------------------------------------
  // State and timers
  // ---------------------------------------------------------------
  logic [NB-1:0]  bank_open;
  logic [NB-1:0]  rc_busy, rcd_busy, ras_busy, pre_busy, max_busy;
  logic [NB-1:0]  act_hit, pre_load;
  logic [CW-1:0]  pre_value [NB];
  logic           rrd_busy, rfc_busy, xsnr_busy, rdblk_busy, wtr_busy;
  logic           accept, all_closed, sr_state;
  logic [ddr_guard_pkg::POSTED_W-1:0] posted;
  logic [CW-1:0]  refi_count;
  logic           refi_tick, issued;

  assign accept     = cmd_valid && cmd_ready;
  assign all_closed = (bank_open == '0);

  // Per-bank timers: row cycle, activate delay, open min/max, reopen
  for (genvar b = 0; b < NB; b++) begin : g_bank
    assign act_hit[b] = accept && (cmd_code == ddr_guard_pkg::CMD_ACT)
                        && (cmd_bank == 2'(b));
    cycle_timer #(.WIDTH(CW)) u_rc (
      .core_clk(core_clk), .sys_rst(sys_rst), .load(act_hit[b]),
      .load_value(spc(t_rc)), .busy(rc_busy[b]));            // RULE1
    cycle_timer #(.WIDTH(CW)) u_rcd (
      .core_clk(core_clk), .sys_rst(sys_rst), .load(act_hit[b]),
      .load_value(spc(t_rcd)), .busy(rcd_busy[b]));          // RULE3
    cycle_timer #(.WIDTH(CW)) u_ras (
      .core_clk(core_clk), .sys_rst(sys_rst), .load(act_hit[b]),
      .load_value(spc(ddr_guard_pkg::OPEN_MIN)),
      .busy(ras_busy[b]));                                   // RULE15
    cycle_timer #(.WIDTH(CW)) u_max (
      .core_clk(core_clk), .sys_rst(sys_rst), .load(act_hit[b]),
      .load_value(CW'(OPEN_MAX_CYC)), .busy(max_busy[b]));   // RULE15
    cycle_timer #(.WIDTH(CW)) u_pre (
      .core_clk(core_clk), .sys_rst(sys_rst), .load(pre_load[b]),
      .load_value(pre_value[b]), .busy(pre_busy[b]));
  end

  // Reopen wait: precharge, read auto-precharge, or write recovery chain
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      pre_load[b]  = 1'b0;
      pre_value[b] = '0;
      if (accept && cmd_bank == b[1:0]) begin
        if (cmd_code == ddr_guard_pkg::CMD_PRE) begin
          pre_load[b]  = 1'b1;
          pre_value[b] = spc(t_rp);
        end else if (cmd_code == ddr_guard_pkg::CMD_READ && cmd_autopre)
        begin
          pre_load[b]  = 1'b1;
          pre_value[b] = spc(BURST_CYCLES + t_rp);
        end else if (cmd_code == ddr_guard_pkg::CMD_WRITE && cmd_autopre)
        begin
          pre_load[b]  = 1'b1;                                // RULE6
          pre_value[b] = spc(1 + BURST_CYCLES + t_wr + t_rp);
        end
      end
    end
  end

  // Shared timers: bank to bank, refresh cycle, exits, write turnaround
  cycle_timer #(.WIDTH(CW)) u_rrd (
    .core_clk(core_clk), .sys_rst(sys_rst), .load(|act_hit),
    .load_value(spc(t_rrd)), .busy(rrd_busy));               // RULE5
  cycle_timer #(.WIDTH(CW)) u_rfc (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .load(accept && cmd_code == ddr_guard_pkg::CMD_REF),
    .load_value(spc(ddr_guard_pkg::REFRESH_CYCLE)),
    .busy(rfc_busy));                                        // RULE2
  cycle_timer #(.WIDTH(CW)) u_xsnr (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .load(accept && cmd_code == ddr_guard_pkg::CMD_SR_EXIT),
    .load_value(spc(ddr_guard_pkg::SR_EXIT_NONREAD)),
    .busy(xsnr_busy));                                       // RULE8
  cycle_timer #(.WIDTH(CW)) u_rdblk (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .load((accept && cmd_code == ddr_guard_pkg::CMD_SR_EXIT)
          || pd_exit_unstable),
    .load_value(pd_exit_unstable
                ? spc(ddr_guard_pkg::POWERDOWN_EXIT_READ_CYC)  // RULE13
                : spc(ddr_guard_pkg::SELFREFRESH_EXIT_READ_CYC)),
    .busy(rdblk_busy));                                      // RULE9
  cycle_timer #(.WIDTH(CW)) u_wtr (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .load(accept && cmd_code == ddr_guard_pkg::CMD_WRITE),
    .load_value(spc(1 + BURST_CYCLES + t_wtr)),
    .busy(wtr_busy));                                        // RULE7

  // ---------------------------------------------------------------
  // Command gate
  // ---------------------------------------------------------------
  // Decide whether the requested command may go out this cycle
  always_comb begin
    logic ok;
    ok = 1'b0;
    case (cmd_code)
      ddr_guard_pkg::CMD_NOP:
        ok = 1'b1;
      ddr_guard_pkg::CMD_ACT:
        ok = !bank_open[cmd_bank] && !rc_busy[cmd_bank]      // RULE1
             && !pre_busy[cmd_bank] && !rrd_busy              // RULE5
             && !rfc_busy && !xsnr_busy;                      // RULE2
      ddr_guard_pkg::CMD_READ:
        ok = bank_open[cmd_bank] && !rcd_busy[cmd_bank]       // RULE4
             && !wtr_busy && !rdblk_busy;                     // RULE7
      ddr_guard_pkg::CMD_WRITE:
        ok = bank_open[cmd_bank] && !rcd_busy[cmd_bank]       // RULE3
             && !xsnr_busy;
      ddr_guard_pkg::CMD_PRE:
        ok = bank_open[cmd_bank] && !ras_busy[cmd_bank]       // RULE15
             && !xsnr_busy;
      ddr_guard_pkg::CMD_REF:
        ok = all_closed && (rc_busy == '0) && (pre_busy == '0)
             && !rfc_busy && !xsnr_busy;                      // RULE1
      ddr_guard_pkg::CMD_SR_ENTER:
        ok = all_closed && (pre_busy == '0) && !rfc_busy
             && !xsnr_busy;
      ddr_guard_pkg::CMD_MODE:
        ok = all_closed && (pre_busy == '0) && !xsnr_busy
             && (cas_latency_setting != ddr_guard_pkg::CL_4); // RULE14
      default:
        ok = 1'b0;
    endcase
    if (sr_state) begin
      cmd_ready = (cmd_code == ddr_guard_pkg::CMD_SR_EXIT);
    end else if (refresh_urgent) begin
      cmd_ready = ok && (cmd_code == ddr_guard_pkg::CMD_REF
                         || cmd_code == ddr_guard_pkg::CMD_PRE); // RULE11
    end else begin
      cmd_ready = ok;
    end
  end

  assign cl_refused = (cas_latency_setting == ddr_guard_pkg::CL_4);

  // ---------------------------------------------------------------
  // Bank and self-refresh state
  // ---------------------------------------------------------------
  // Track open banks; auto-precharge closes the bank with its access
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bank_open <= '0;
    end else if (accept) begin
      if (cmd_code == ddr_guard_pkg::CMD_ACT) begin
        bank_open[cmd_bank] <= 1'b1;
      end else if (cmd_code == ddr_guard_pkg::CMD_PRE
                   || ((cmd_code == ddr_guard_pkg::CMD_READ
                        || cmd_code == ddr_guard_pkg::CMD_WRITE)
                       && cmd_autopre)) begin
        bank_open[cmd_bank] <= 1'b0;
      end
    end
  end

  // Self refresh entry and exit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sr_state <= 1'b0;
    end else if (accept && cmd_code == ddr_guard_pkg::CMD_SR_ENTER) begin
      sr_state <= 1'b1;
    end else if (accept && cmd_code == ddr_guard_pkg::CMD_SR_EXIT) begin
      sr_state <= 1'b0;
    end
  end

  assign in_self_refresh = sr_state;
  assign bank_overdue    = bank_open & ~max_busy;            // RULE15

  // ---------------------------------------------------------------
  // Refresh bookkeeping
  // ---------------------------------------------------------------
  // Interval counter; the device refreshes itself in self refresh
  assign refi_tick = (refi_count == '0) && !sr_state;
  always_ff @(posedge core_clk) begin
    if (sys_rst || sr_state || refi_tick) begin
      refi_count <= temp_hot ? spc(ddr_guard_pkg::REFI_HOT)
                             : spc(ddr_guard_pkg::REFI_NORMAL); // RULE10
    end else begin
      refi_count <= refi_count - 1'b1;
    end
  end

  // Owed refreshes; a tick in the same cycle as a refresh cancels out
  assign issued = accept && (cmd_code == ddr_guard_pkg::CMD_REF);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      posted <= '0;
    end else if (refi_tick && !issued
                 && posted != ddr_guard_pkg::REFRESH_POSTED_MAX) begin
      posted <= posted + 1'b1;
    end else if (issued && !refi_tick && posted != '0) begin
      posted <= posted - 1'b1;
    end
  end

  assign refresh_due    = (posted != '0);
  assign refresh_urgent =
    (posted == ddr_guard_pkg::POSTED_W'(ddr_guard_pkg::REFRESH_POSTED_MAX));

  // ---------------------------------------------------------------
  // Device pins
  // ---------------------------------------------------------------
  // Register the command onto the pins the cycle after acceptance
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= ddr_guard_pkg::PINS_NOP;
      ddr_ba   <= '0;
      ddr_addr <= '0;
      ddr_cke  <= 1'b1;
    end else begin
      ddr_ba   <= cmd_bank;
      ddr_addr <= '0;
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= ddr_guard_pkg::PINS_NOP;
      if (accept) begin
        case (cmd_code)
          ddr_guard_pkg::CMD_ACT: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <=
              ddr_guard_pkg::PINS_ACT;
            ddr_addr <= cmd_addr;
          end
          ddr_guard_pkg::CMD_READ, ddr_guard_pkg::CMD_WRITE: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <=
              (cmd_code == ddr_guard_pkg::CMD_READ)
              ? ddr_guard_pkg::PINS_READ : ddr_guard_pkg::PINS_WRIT;
            ddr_addr <= cmd_addr;
            ddr_addr[ddr_guard_pkg::AP_BIT] <= cmd_autopre;
          end
          ddr_guard_pkg::CMD_PRE:
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <=
              ddr_guard_pkg::PINS_PRE;
          ddr_guard_pkg::CMD_REF, ddr_guard_pkg::CMD_SR_ENTER: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <=
              ddr_guard_pkg::PINS_REF;                         // RULE12
            ddr_cke <= (cmd_code == ddr_guard_pkg::CMD_REF);
          end
          ddr_guard_pkg::CMD_SR_EXIT:
            ddr_cke <= 1'b1;
          ddr_guard_pkg::CMD_MODE: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <=
              ddr_guard_pkg::PINS_MODE;
            ddr_addr <= cmd_addr;
          end
          default: ;
        endcase
      end
    end
  end

endmodule

// ==== design/ddr_guard_pkg.sv ====
// Constants, command codes and cycle conversions for the DDR command guard
package ddr_guard_pkg;

  // ---------------------------------------------------------------
  // Clock and conversion
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;     // 200 MHz core clock

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time in ns to whole cycles, rounded down, never below one
  function automatic int cyc_max(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // ---------------------------------------------------------------
  // Timing figures, faster grade then slower grade
  // ---------------------------------------------------------------
  localparam int ROW_CYCLE_MIN_FAST_NS       = 50;
  localparam int ROW_CYCLE_MIN_SLOW_NS       = 54;
  localparam int REFRESH_CYCLE_MIN_NS        = 70;
  localparam int RAS_TO_CAS_FAST_NS          = 15;
  localparam int RAS_TO_CAS_SLOW_NS          = 18;
  localparam int PRECHARGE_PERIOD_FAST_NS    = 15;
  localparam int PRECHARGE_PERIOD_SLOW_NS    = 18;
  localparam int BANK_TO_BANK_FAST_NS        = 10;
  localparam int BANK_TO_BANK_SLOW_NS        = 12;
  localparam int WRITE_RECOVERY_FAST_NS      = 15;
  localparam int WRITE_RECOVERY_SLOW_NS      = 12;
  localparam int BANK_OPEN_MIN_NS            = 40;
  localparam int BANK_OPEN_MAX_NS            = 70000;
  localparam int SELFREFRESH_EXIT_NONREAD_NS = 75;
  localparam int REFRESH_INTERVAL_NORMAL_NS  = 15600;
  localparam int REFRESH_INTERVAL_HOT_NS     = 3900;

  // Figures given directly in clock cycles or in refresh commands
  localparam int WRITE_TO_READ_FAST_CYC      = 2;
  localparam int WRITE_TO_READ_SLOW_CYC      = 1;
  localparam int SELFREFRESH_EXIT_READ_CYC   = 200;
  localparam int POWERDOWN_EXIT_READ_CYC     = 200;
  localparam int REFRESH_POSTED_MAX          = 8;

  // Cycle counts at the core clock
  localparam int ROW_CYCLE_FAST  = cyc_min(ROW_CYCLE_MIN_FAST_NS);
  localparam int ROW_CYCLE_SLOW  = cyc_min(ROW_CYCLE_MIN_SLOW_NS);
  localparam int REFRESH_CYCLE   = cyc_min(REFRESH_CYCLE_MIN_NS);
  localparam int RCD_FAST        = cyc_min(RAS_TO_CAS_FAST_NS);
  localparam int RCD_SLOW        = cyc_min(RAS_TO_CAS_SLOW_NS);
  localparam int PRECHARGE_FAST  = cyc_min(PRECHARGE_PERIOD_FAST_NS);
  localparam int PRECHARGE_SLOW  = cyc_min(PRECHARGE_PERIOD_SLOW_NS);
  localparam int RRD_FAST        = cyc_min(BANK_TO_BANK_FAST_NS);
  localparam int RRD_SLOW        = cyc_min(BANK_TO_BANK_SLOW_NS);
  localparam int WRITE_REC_FAST  = cyc_min(WRITE_RECOVERY_FAST_NS);
  localparam int WRITE_REC_SLOW  = cyc_min(WRITE_RECOVERY_SLOW_NS);
  localparam int OPEN_MIN        = cyc_min(BANK_OPEN_MIN_NS);
  localparam int OPEN_MAX        = cyc_max(BANK_OPEN_MAX_NS);
  localparam int SR_EXIT_NONREAD = cyc_min(SELFREFRESH_EXIT_NONREAD_NS);
  localparam int REFI_NORMAL     = cyc_max(REFRESH_INTERVAL_NORMAL_NS);
  localparam int REFI_HOT        = cyc_max(REFRESH_INTERVAL_HOT_NS);

  // ---------------------------------------------------------------
  // Commands, latency codes and pin encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE,
    CMD_REF, CMD_SR_ENTER, CMD_SR_EXIT, CMD_MODE
  } cmd_type;

  typedef enum logic [1:0] {
    CL_2, CL_2P5, CL_3, CL_4
  } cas_latency_type;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PINS_NOP  = 4'h7;
  localparam logic [3:0] PINS_ACT  = 4'h3;
  localparam logic [3:0] PINS_READ = 4'h5;
  localparam logic [3:0] PINS_WRIT = 4'h4;
  localparam logic [3:0] PINS_PRE  = 4'h2;
  localparam logic [3:0] PINS_REF  = 4'h1;
  localparam logic [3:0] PINS_MODE = 4'h0;

  localparam int AP_BIT     = 10;        // auto-precharge address bit
  localparam int ADDR_W     = 12;
  localparam int BANKS      = 4;
  localparam int POSTED_W   = 4;

endpackage

// ==== verification/ddr_command_timing_guard_tb.sv ====
// Self-checking bench for the DDR command guard
`timescale 1ns/1ps
module ddr_command_timing_guard_tb;
  typedef struct packed {
    logic [3:0] code; logic [1:0] bank; logic ap; logic [7:0] n;
    logic [3:0] pin;
  } row_type;
  row_type rows [12];
  logic core_clk = 1'b0, sys_rst = 1'b1, speed_slow = 1'b0, temp_hot = 1'b1;
  ddr_guard_pkg::cas_latency_type cas_latency_setting = ddr_guard_pkg::CL_3;
  ddr_guard_pkg::cmd_type cmd_code = ddr_guard_pkg::CMD_NOP;
  logic pd_exit_unstable = 1'b0, cmd_valid = 1'b0, cmd_autopre = 1'b0;
  logic [1:0] cmd_bank = 2'h0, ddr_ba;
  logic [11:0] cmd_addr = 12'h0A5, ddr_addr, ref_row;
  logic cmd_ready, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
  logic refresh_due, refresh_urgent, cl_refused, in_self_refresh;
  logic [3:0] bank_overdue, last_pin = 4'h7;
  logic [7:0] bad_cmds;
  int num_errors = 0, checks_done = 0, w;
  wire [3:0] pins = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  ddr_command_timing_guard i_dut (.core_clk, .sys_rst, .speed_slow,
    .temp_hot, .cas_latency_setting, .pd_exit_unstable, .cmd_valid,
    .cmd_code, .cmd_bank, .cmd_addr, .cmd_autopre, .cmd_ready, .ddr_cke,
    .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr,
    .refresh_due, .refresh_urgent, .bank_overdue, .cl_refused,
    .in_self_refresh);
  ddr_device_model i_mem (.core_clk, .pins, .ddr_ba, .ddr_addr, .bad_cmds,
    .ref_row);
  // Clock and watchdog
  initial forever #2.5 core_clk = ~core_clk;
  initial begin
    #80000;
    num_errors++;
    close_out();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  // Request held until taken
  task automatic go(input row_type r);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_code <= ddr_guard_pkg::cmd_type'(r.code);
    cmd_bank <= r.bank;
    cmd_autopre <= r.ap;
    @(negedge core_clk);
    if (last_pin != 4'hF) check(pins, last_pin);
    while (cmd_ready !== 1'b1 && n < 300) begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    last_pin = r.pin;
    if (r.n != 8'hFF) check(n, r.n);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rows = '{'{1, 0, 0, 0, 3}, '{1, 1, 0, 1, 3}, '{2, 1, 1, 2, 5},
      '{4, 0, 0, 2, 2}, '{1, 0, 0, 2, 3}, '{4, 0, 0, 7, 2}, '{5, 0, 0, 2, 1},
      '{1, 2, 0, 13, 3}, '{3, 2, 0, 2, 4}, '{2, 2, 0, 4, 5},
      '{3, 2, 1, 0, 4}, '{1, 2, 0, 8, 3}};
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check({ddr_cke, refresh_due, in_self_refresh}, 3'h4);
    @(posedge core_clk);
    foreach (rows[i]) go(rows[i]);
    go('{4, 2, 0, 8'hFF, 2});
    go('{6, 0, 0, 8'hFF, 4'hF});
    cmd_code <= ddr_guard_pkg::CMD_READ;
    @(negedge core_clk);
    check({ddr_cke, in_self_refresh, cmd_ready}, 3'h2);
    @(posedge core_clk);
    go('{7, 0, 0, 8'hFF, 4'hF});
    go('{1, 0, 0, 14, 3});
    go('{2, 0, 0, 184, 5});
    cmd_valid <= 1'b0;
    pd_exit_unstable <= 1'b1;
    @(posedge core_clk);
    pd_exit_unstable <= 1'b0;
    last_pin = 4'h7;
    go('{2, 0, 0, 199, 5});
    cas_latency_setting <= ddr_guard_pkg::CL_4;
    cmd_code <= ddr_guard_pkg::CMD_MODE;
    @(negedge core_clk);
    check({cl_refused, cmd_ready}, 2'h2);
    @(posedge core_clk);
    cas_latency_setting <= ddr_guard_pkg::CL_3;
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    check(cl_refused, 1'b0);
    for (w = 0; refresh_urgent !== 1'b1 && w < 8000; w++) @(negedge core_clk);
    check({refresh_urgent, refresh_due}, 2'h3);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= ddr_guard_pkg::CMD_ACT;
    cmd_bank <= 2'h1;
    @(negedge core_clk);
    check(cmd_ready, 1'b0);
    check({bad_cmds, ref_row}, 20'h00002);
    close_out();
  end
endmodule

// ==== verification/ddr_device_model.sv ====
// Behavioural four-bank memory watching the command pins
`timescale 1ns/1ps
module ddr_device_model (
  input  wire logic        core_clk,  // Clock
  input  wire logic [3:0]  pins,      // cs_n ras_n cas_n we_n
  input  wire logic [1:0]  ddr_ba,    // Bank
  input  wire logic [11:0] ddr_addr,  // Address
  output logic [7:0]       bad_cmds,  // Rejected commands
  output logic [11:0]      ref_row    // Internal refresh row
);
  logic [3:0] open_bank = 4'h0;
  initial {bad_cmds, ref_row} = 20'h00000;
  // Tracks open banks and counts illegal commands
  always @(posedge core_clk) begin
    logic bad, col;
    col = pins == 4'h5 || pins == 4'h4;
    bad = (pins == 4'h3 && open_bank[ddr_ba]) || (col && !open_bank[ddr_ba])
      || (pins == 4'h1 && open_bank != 4'h0);
    bad_cmds <= bad_cmds + {7'h00, bad};
    if (pins == 4'h3) open_bank[ddr_ba] <= 1'b1;
    if (pins == 4'h2 || (col && ddr_addr[10])) open_bank[ddr_ba] <= 1'b0;
    if (pins == 4'h1) ref_row <= ref_row + 12'h001;
  end
endmodule

// ==== verification/ddr_guard_checker.sv ====
// Concurrent timing checks on the DDR command guard ports
`timescale 1ns/1ps
module ddr_guard_checker (
  input wire logic        core_clk,    // Clock
  input wire logic        sys_rst,     // Reset
  input wire logic        speed_slow,  // Grade
  input wire logic [1:0]  cas_latency_setting, // CL
  input wire logic        pd_exit_unstable, // Pulse
  input wire logic        cmd_valid,   // Request
  input wire logic [3:0]  cmd_code,    // Command
  input wire logic [1:0]  cmd_bank,    // Bank
  input wire logic        cmd_ready,   // May issue
  input wire logic        ddr_cke,     // Clock enable
  input wire logic        ddr_cs_n,    // Select
  input wire logic        ddr_ras_n,   // Row strobe
  input wire logic        ddr_cas_n,   // Col strobe
  input wire logic        ddr_we_n,    // Write
  input wire logic [1:0]  ddr_ba,      // Bank pins
  input wire logic [11:0] ddr_addr,    // Address
  input wire logic        refresh_urgent, // At limit
  input wire logic        cl_refused,  // CL 4 flag
  input wire logic        in_self_refresh // Asleep
);
  logic [7:0] rd_wait;
  wire  [3:0] pins = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  wire        act  = pins == ddr_guard_pkg::PINS_ACT;
  wire        rd   = pins == ddr_guard_pkg::PINS_READ;
  wire        col  = rd || pins == ddr_guard_pkg::PINS_WRIT;
  wire        rf   = pins == ddr_guard_pkg::PINS_REF;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // READ lockout after a clock restart
  always_ff @(posedge core_clk) begin
    if (sys_rst) rd_wait <= 8'h00;
    else if (pd_exit_unstable) rd_wait <= 8'hC8;
    else if ($rose(ddr_cke)) rd_wait <= 8'hC7;
    else if (rd_wait != 8'h00) rd_wait <= rd_wait - 8'h01;
  end
  a_col_after_act: assert property (col && !speed_slow |->
    !($past(act) && $past(ddr_ba) == ddr_ba) &&
    !($past(act, 2) && $past(ddr_ba, 2) == ddr_ba))
    else $error("early column");
  a_bank_act_gap: assert property (act && !speed_slow |=> !act)
    else $error("close activates");
  a_refresh_gap: assert property (rf |=> (!act && !rf) [*8]
    ##1 (!act && !rf) [*5]) else $error("early after refresh");
  a_sleep_only_exit: assert property (in_self_refresh && cmd_valid
    && cmd_code != ddr_guard_pkg::CMD_SR_EXIT |-> !cmd_ready)
    else $error("taken in self refresh");
  a_urgent_ref_pre: assert property (refresh_urgent && cmd_valid
    && cmd_code != ddr_guard_pkg::CMD_REF
    && cmd_code != ddr_guard_pkg::CMD_PRE |-> !cmd_ready)
    else $error("taken at refresh limit");
  a_cl4_refused: assert property ((cas_latency_setting
    == ddr_guard_pkg::CL_4) == cl_refused && !(cl_refused && cmd_ready
    && cmd_code == ddr_guard_pkg::CMD_MODE))
    else $error("CL4 not refused");
  a_read_lockout: assert property (rd |-> rd_wait == 8'h00)
    else $error("early read");
  a_ref_no_addr: assert property (rf |-> ddr_addr == 12'h000)
    else $error("refresh address");
  a_take_to_pins: assert property (cmd_valid && cmd_ready
    && cmd_code == ddr_guard_pkg::CMD_ACT |=> act
    && ddr_ba == $past(cmd_bank)) else $error("activate lost");
endmodule
bind ddr_command_timing_guard ddr_guard_checker i_chk (.core_clk, .sys_rst,
  .speed_slow, .cas_latency_setting, .pd_exit_unstable, .cmd_valid,
  .cmd_code, .cmd_bank, .cmd_ready, .ddr_cke, .ddr_cs_n, .ddr_ras_n,
  .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr, .refresh_urgent, .cl_refused,
  .in_self_refresh);
